// ==== verilog/scc_pkg.sv ====
// How it works
// - Any of four oscillator sources may drive the main core clock.
// - Sources: fast external crystal, fast internal RC, slow crystal, slow RC.
// - After reset run from fast internal RC divided by eight.
// - Prescaler and source selection are writable right after reset.
// - Programmable prescaler sets core and peripheral clock rate.
// - Source change in run mode without glitch on distributed clock.
// - Core, each peripheral and memory clocks can be stopped independently.
// - Failure monitor stays off until software enables it.
// - Detected fast crystal failure switches main clock to fast internal RC.
// - Calendar and display clocks pick any source, independent of main clock.
// - Configurable clock output pin driven from the clock tree.
// - Active-halt stops core and peripheral clocks, keeps calendar running.
package scc_pkg;
    localparam int NUM_PERIPH = 8;
    localparam int PRESC_W = 3;
    localparam int DIV_W = 8;
    localparam logic [PRESC_W-1:0] PRESC_RST = 3'h3;
    localparam logic [7:0] FAIL_TIMEOUT = 8'h40;
    localparam logic [1:0] SRC_FAST_XTAL = 2'h0;
    localparam logic [1:0] SRC_FAST_RC = 2'h1;
    localparam logic [1:0] SRC_SLOW_XTAL = 2'h2;
    localparam logic [1:0] SRC_SLOW_RC = 2'h3;

    typedef struct packed {
        logic [1:0] main_src;
        logic [PRESC_W-1:0] presc;
        logic [1:0] cal_src;
        logic [1:0] disp_src;
        logic [1:0] out_src;
        logic [PRESC_W-1:0] out_presc;
        logic out_en;
        logic core_gate;
        logic mem_gate;
        logic [NUM_PERIPH-1:0] periph_gate;
        logic monitor_en;
        logic active_halt;
    } scc_cfg_t;

    typedef struct packed {
        logic [3:0] osc_tick;
        logic [3:0] osc_ready;
    } scc_osc_t;

    typedef struct packed {
        logic [1:0] cur_src;
        logic switch_busy;
        logic xtal_failed;
        logic fail_evt;
    } scc_stat_t;
endpackage

// ==== verilog/scc_div.sv ====
`timescale 1ns/1ps
module scc_div (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic tick_i,
    input wire logic [scc_pkg::PRESC_W-1:0] presc_i,
    output logic en_o
);
    import scc_pkg::*;
    logic [DIV_W-1:0] cnt_r;
    logic [DIV_W-1:0] cnt_nxt;
    logic en_r;
    logic en_nxt;
    logic [DIV_W-1:0] last;

    always_comb begin
        last = DIV_W'((9'h1 << presc_i) - 9'h1);
        cnt_nxt = cnt_r;
        en_nxt = 1'b0;
        if (tick_i) begin
            // Ratio 2^presc; wrap also when ratio shrinks below count
            if (cnt_r >= last) begin
                cnt_nxt = '0;
                en_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r + 8'h1;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            cnt_r <= '0;
            en_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            en_r <= en_nxt;
        end
    end
    assign en_o = en_r;
endmodule

// ==== verilog/scc_top.sv ====
`timescale 1ns/1ps
module scc_top (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire scc_pkg::scc_osc_t osc_i,
    input wire scc_pkg::scc_cfg_t cfg_i,
    output scc_pkg::scc_stat_t stat_o,
    output logic core_en_o,
    output logic mem_en_o,
    output logic [scc_pkg::NUM_PERIPH-1:0] periph_en_o,
    output logic cal_en_o,
    output logic disp_en_o,
    output logic clk_out_o
);
    import scc_pkg::*;

    // Pins from oscillators cross into this domain first
    scc_osc_t osc_m_r;
    scc_osc_t osc_s_r;
    logic [3:0] tick_prev_r;
    logic [3:0] tick_evt;

    // Chain runs through reset so no false tick edge follows release
    always_ff @(posedge ref_clk_i) begin
        osc_m_r <= osc_i;
        osc_s_r <= osc_m_r;
        tick_prev_r <= osc_s_r.osc_tick;
    end
    assign tick_evt = osc_s_r.osc_tick & ~tick_prev_r;

    // Source switch state
    typedef enum logic [1:0] {ST_RUN, ST_WAIT, ST_SWAP} scc_sw_st_t;
    scc_sw_st_t st_r;
    scc_sw_st_t st_nxt;
    logic [1:0] cur_r;
    logic [1:0] cur_nxt;
    logic [1:0] tgt_r;
    logic [1:0] tgt_nxt;
    logic failed_r;
    logic failed_nxt;
    logic fail_evt_r;
    logic fail_evt_nxt;
    logic mon_on_r;
    logic mon_on_nxt;
    logic [7:0] mon_cnt_r;
    logic [7:0] mon_cnt_nxt;
    logic busy_r;
    logic busy_nxt;
    logic [PRESC_W-1:0] presc_r;
    logic [PRESC_W-1:0] presc_nxt;
    logic main_tick;
    logic fail_now;

    always_comb begin
        st_nxt = st_r;
        cur_nxt = cur_r;
        tgt_nxt = tgt_r;
        failed_nxt = failed_r;
        fail_evt_nxt = 1'b0;
        mon_on_nxt = cfg_i.monitor_en;
        mon_cnt_nxt = mon_cnt_r;
        presc_nxt = cfg_i.presc;
        fail_now = 1'b0;
        // Monitor counts reference cycles between crystal edges
        if (!mon_on_r || tick_evt[SRC_FAST_XTAL]) begin
            mon_cnt_nxt = '0;
        end else if (mon_cnt_r != FAIL_TIMEOUT) begin
            mon_cnt_nxt = mon_cnt_r + 8'h1;
        end
        if (mon_on_r && mon_cnt_r == FAIL_TIMEOUT && !failed_r) begin
            fail_now = 1'b1;
        end
        // Failure flag is sticky until monitor is disabled
        if (fail_now) begin
            failed_nxt = 1'b1;
            fail_evt_nxt = 1'b1;
        end else if (!cfg_i.monitor_en) begin
            failed_nxt = 1'b0;
        end
        unique case (st_r)
            ST_RUN: begin
                if (cfg_i.main_src != cur_r &&
                    !(failed_r && cfg_i.main_src == SRC_FAST_XTAL)) begin
                    tgt_nxt = cfg_i.main_src;
                    st_nxt = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (osc_s_r.osc_ready[tgt_r]) begin
                    st_nxt = ST_SWAP;
                end else if (cfg_i.main_src != tgt_r) begin
                    st_nxt = ST_RUN;
                end
            end
            ST_SWAP: begin
                // Change only on an old-source edge so no runt cycle
                if (tick_evt[cur_r]) begin
                    cur_nxt = tgt_r;
                    st_nxt = ST_RUN;
                end
            end
        endcase
        if (fail_now && cur_r == SRC_FAST_XTAL) begin
            cur_nxt = SRC_FAST_RC;
            st_nxt = ST_RUN;
        end else if (fail_now && tgt_r == SRC_FAST_XTAL && st_r != ST_RUN) begin
            st_nxt = ST_RUN;
        end
        busy_nxt = (st_nxt != ST_RUN);
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            st_r <= ST_RUN;
            cur_r <= SRC_FAST_RC;
            tgt_r <= SRC_FAST_RC;
            failed_r <= 1'b0;
            fail_evt_r <= 1'b0;
            mon_on_r <= 1'b0;
            mon_cnt_r <= '0;
            busy_r <= 1'b0;
            presc_r <= PRESC_RST;
        end else begin
            st_r <= st_nxt;
            cur_r <= cur_nxt;
            tgt_r <= tgt_nxt;
            failed_r <= failed_nxt;
            fail_evt_r <= fail_evt_nxt;
            mon_on_r <= mon_on_nxt;
            mon_cnt_r <= mon_cnt_nxt;
            busy_r <= busy_nxt;
            presc_r <= presc_nxt;
        end
    end

    assign main_tick = tick_evt[cur_r];

    // Prescaler loads its reset ratio of eight, then follows cfg_i.presc every cycle
    logic presc_en;
    scc_div u_main_div (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .tick_i(main_tick),
        .presc_i(presc_r),
        .en_o(presc_en)
    );

    logic out_base;
    logic out_en;
    assign out_base = tick_evt[cfg_i.out_src];
    scc_div u_out_div (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .tick_i(out_base),
        .presc_i(cfg_i.out_presc),
        .en_o(out_en)
    );

    logic core_en_nxt;
    logic mem_en_nxt;
    logic [NUM_PERIPH-1:0] periph_en_nxt;
    logic cal_en_nxt;
    logic disp_en_nxt;
    logic clk_out_nxt;
    logic core_en_r;
    logic mem_en_r;
    logic [NUM_PERIPH-1:0] periph_en_r;
    logic cal_en_r;
    logic disp_en_r;
    logic clk_out_r;

    always_comb begin
        core_en_nxt = presc_en && cfg_i.core_gate && !cfg_i.active_halt;
        mem_en_nxt = presc_en && cfg_i.mem_gate && !cfg_i.active_halt;
        periph_en_nxt = cfg_i.active_halt ? '0 :
            ({NUM_PERIPH{presc_en}} & cfg_i.periph_gate);
        cal_en_nxt = tick_evt[cfg_i.cal_src];
        disp_en_nxt = tick_evt[cfg_i.disp_src];
        clk_out_nxt = clk_out_r;
        if (!cfg_i.out_en) begin
            clk_out_nxt = 1'b0;
        end else if (out_en) begin
            clk_out_nxt = !clk_out_r;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            core_en_r <= 1'b0;
            mem_en_r <= 1'b0;
            periph_en_r <= '0;
            cal_en_r <= 1'b0;
            disp_en_r <= 1'b0;
            clk_out_r <= 1'b0;
        end else begin
            core_en_r <= core_en_nxt;
            mem_en_r <= mem_en_nxt;
            periph_en_r <= periph_en_nxt;
            cal_en_r <= cal_en_nxt;
            disp_en_r <= disp_en_nxt;
            clk_out_r <= clk_out_nxt;
        end
    end

    assign core_en_o = core_en_r;
    assign mem_en_o = mem_en_r;
    assign periph_en_o = periph_en_r;
    assign cal_en_o = cal_en_r;
    assign disp_en_o = disp_en_r;
    assign clk_out_o = clk_out_r;
    assign stat_o = '{cur_src: cur_r, switch_busy: busy_r, xtal_failed: failed_r,
        fail_evt: fail_evt_r};
endmodule

// ==== tb/scc_osc_model.sv ====
`timescale 1ns/1ps
module scc_osc_model (
    input wire logic xtal_stop_i,
    output scc_pkg::scc_osc_t osc_o
);
    import scc_pkg::*;
    logic w0 = 0, w1 = 0, w2 = 0, w3 = 0;
    logic [3:0] rdy = 4'h0;
    // Stopped crystal holds its level, like a dead oscillator
    always #100 w0 = xtal_stop_i ? w0 : ~w0;
    always #50 w1 = ~w1;
    always #200 w2 = ~w2;
    always #400 w3 = ~w3;
    initial #500 rdy = 4'hf;
    assign osc_o = '{osc_tick: {w3, w2, w1, w0}, osc_ready: rdy};
endmodule

// ==== tb/scc_top_assertions.sv ====
`timescale 1ns/1ps
module scc_top_assertions
    import scc_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire scc_pkg::scc_cfg_t cfg_i,
    input wire scc_pkg::scc_stat_t stat_o,
    input wire logic core_en_o,
    input wire logic clk_out_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    core_gate_a: assert property (
        core_en_o |-> $past(cfg_i.core_gate) && !$past(cfg_i.active_halt))
        else $error("core enable while gated");
    core_pulse_a: assert property (core_en_o |=> !core_en_o)
        else $error("core enable too long");
    // Three low samples: a timeout in the cycle of the clear still sets the flag
    mon_off_a: assert property (
        !cfg_i.monitor_en [*3] |-> !stat_o.xtal_failed && !stat_o.fail_evt)
        else $error("monitor acts while off");
    fail_evt_a: assert property ($rose(stat_o.xtal_failed) |-> stat_o.fail_evt)
        else $error("no failure event");
    evt_pulse_a: assert property (stat_o.fail_evt |=> !stat_o.fail_evt)
        else $error("failure event too long");
    fail_swap_a: assert property (
        $rose(stat_o.xtal_failed) && $past(stat_o.cur_src) == SRC_FAST_XTAL
        |-> stat_o.cur_src == SRC_FAST_RC)
        else $error("no fallback to rc");
    swap_wait_a: assert property (
        $changed(stat_o.cur_src) && !$rose(stat_o.xtal_failed)
        |-> $past(stat_o.switch_busy))
        else $error("source changed without switch");
    out_off_a: assert property (!cfg_i.out_en [*2] |-> !clk_out_o)
        else $error("clock output while off");
    cover property (stat_o.fail_evt);
    cover property ($rose(stat_o.xtal_failed) && stat_o.cur_src == SRC_FAST_RC);
    cover property ($rose(stat_o.switch_busy));
    cover property (core_en_o);
endmodule
bind scc_top scc_top_assertions chk (.ref_clk_i, .rst_i, .cfg_i, .stat_o, .core_en_o, .clk_out_o);

// ==== tb/scc_top_tb.sv ====
`timescale 1ns/1ps
module scc_top_tb;
    import scc_pkg::*;
    typedef struct {logic [1:0] src; logic [2:0] presc; int core;} scc_row_t;
    scc_row_t rows[4] = '{'{2'h1, 3'h3, 20}, '{2'h0, 3'h1, 40}, '{2'h2, 3'h2, 10}, '{2'h3, 3'h0, 20}};
    int tk[4] = '{80, 160, 40, 20};
    logic ref_clk_i = 0;
    logic rst_i = 1;
    logic stop = 0;
    logic core, mem, cal, disp, cko, pk;
    logic [7:0] per;
    scc_cfg_t cfg;
    scc_osc_t osc;
    scc_stat_t st;
    int err_total = 0, n_tests = 0, cyc = 0, nc, nm, np, ncal, nd, nck, nph;
    always #12.5 ref_clk_i = ~ref_clk_i;
    scc_osc_model osc_m (.xtal_stop_i(stop), .osc_o(osc));
    scc_top uut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .osc_i(osc), .cfg_i(cfg), .stat_o(st),
        .core_en_o(core), .mem_en_o(mem), .periph_en_o(per), .cal_en_o(cal), .disp_en_o(disp),
        .clk_out_o(cko));
    task conclude;
        $display("checks %0d errors %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task chk(string n, int e, logic [31:0] g, int tol);
        n_tests++;
        if ($isunknown(g) || int'(g) < e - tol || int'(g) > e + tol) begin
            err_total++;
            $display("Error %s expected %0d seen %0d", n, e, g);
        end
    endtask
    task meas;
        nc = 0; nm = 0; np = 0; ncal = 0; nd = 0; nck = 0; pk = cko;
        nph = 0;
        repeat (640) @(posedge ref_clk_i) begin
            nc += core; nm += mem; np += per[0]; ncal += cal; nd += disp;
            nph += int'(per[7:1] != 7'h0);
            nck += (cko && !pk);
            pk = cko;
        end
    endtask
    task sel(logic [1:0] s);
        @(posedge ref_clk_i) cfg.main_src <= s;
        repeat (3) @(posedge ref_clk_i);
        for (int i = 0; i < 400 && (st.switch_busy !== 1'b0 || st.cur_src !== s); i++)
            @(posedge ref_clk_i);
    endtask
    always @(posedge ref_clk_i) begin
        cyc++;
        // Whole run needs about 4300 cycles
        if (cyc == 20000) begin
            err_total++;
            conclude;
        end
    end
    initial begin
        cfg = '0;
        cfg.presc = 3'h3;
        cfg.main_src = SRC_FAST_RC;
        cfg.core_gate = 1;
        cfg.mem_gate = 1;
        cfg.periph_gate = 8'hff;
        repeat (8) @(posedge ref_clk_i);
        rst_i <= 0;
        chk("cur_src", 1, st.cur_src, 0);
        chk("mem", 0, mem, 0);
        foreach (rows[i]) begin
            @(posedge ref_clk_i);
            cfg.presc <= rows[i].presc;
            cfg.cal_src <= 2'(i);
            cfg.disp_src <= 2'(3 - i);
            sel(rows[i].src);
            chk("cur_src", rows[i].src, st.cur_src, 0);
            meas;
            chk("core", rows[i].core, nc, 1);
            chk("mem", rows[i].core, nm, 1);
            chk("cal", tk[i], ncal, 1);
            chk("disp", tk[3 - i], nd, 1);
            $display("row %0d done", i);
        end
        @(posedge ref_clk_i);
        cfg.core_gate <= 0;
        cfg.periph_gate <= 8'h01;
        cfg.out_en <= 1;
        cfg.out_src <= SRC_FAST_RC;
        cfg.out_presc <= 3'h1;
        meas;
        chk("core", 0, nc, 1);
        chk("periph0", 20, np, 1);
        chk("periph_hi", 0, nph, 1);
        chk("clk_out", 40, nck, 1);
        @(posedge ref_clk_i);
        cfg.active_halt <= 1;
        cfg.out_en <= 0;
        meas;
        chk("mem", 0, nm, 1);
        chk("periph0", 0, np, 1);
        chk("cal", tk[3], ncal, 1);
        chk("disp", tk[0], nd, 1);
        chk("clk_out", 0, nck, 1);
        $display("gating done");
        @(posedge ref_clk_i) cfg.active_halt <= 0;
        sel(SRC_FAST_XTAL);
        stop <= 1;
        repeat (200) @(posedge ref_clk_i);
        chk("failed", 0, st.xtal_failed, 0);
        cfg.monitor_en <= 1;
        repeat (100) @(posedge ref_clk_i);
        chk("failed", 1, st.xtal_failed, 0);
        chk("cur_src", 1, st.cur_src, 0);
        $display("failure done");
        cfg.monitor_en <= 0;
        stop <= 0;
        repeat (8) @(posedge ref_clk_i);
        chk("failed", 0, st.xtal_failed, 0);
        sel(SRC_SLOW_XTAL);
        chk("cur_src", 2, st.cur_src, 0);
        $display("recovery done");
        rst_i <= 1;
        repeat (2) @(posedge ref_clk_i);
        chk("cur_src", 1, st.cur_src, 0);
        chk("mem", 0, mem, 0);
        chk("cal", 0, cal, 0);
        repeat (2) @(posedge ref_clk_i);
        rst_i <= 0;
        sel(SRC_SLOW_RC);
        chk("cur_src", 3, st.cur_src, 0);
        $display("reset done");
        conclude;
    end
endmodule
